// *** src/irq_ctrl_regs.svh ***
`ifndef IRQ_CTRL_REGS_SVH
`define IRQ_CTRL_REGS_SVH

// register byte offsets on the wishbone bus
`define OFS_INT_ENABLE   8'hA8
`define OFS_INT_LEVEL    8'hB8
`define OFS_FLAGS        8'hC0
`define OFS_SERVICE      8'hC4
`define OFS_POWER_CTL    8'h87

// field positions inside interrupt_enable_reg
`define BIT_GLOBAL_GATE  7
`define NUM_SOURCES      6

// reset values
`define RST_INT_ENABLE   8'h00
`define RST_INT_LEVEL    8'h00
`define RST_POWER_CTL    8'h00

// power control: idle bit position
`define BIT_IDLE         0

// fixed vectors, external 0 first
`define VEC_EXT0         16'h0003
`define VEC_TMR0         16'h000B
`define VEC_EXT1         16'h0013
`define VEC_TMR1         16'h001B
`define VEC_SER          16'h0023
`define VEC_TMR2         16'h002B

`endif

// *** src/irq_ctrl_pkg.sv ***
package irq_ctrl_pkg;

   typedef logic [5:0] src_vec_t;

   // raw flag inputs from peripherals
   typedef struct packed {
      logic outside_line0_flag;
      logic timer0_rollover_flag;
      logic outside_line1_flag;
      logic timer1_rollover_flag;
      logic receive_done_flag;
      logic transmit_done_flag;
      logic timer2_rollover_flag;
      logic timer2_outside_reload_flag;
   } flag_in_s;

   // vector call request to the core sequencer
   typedef struct packed {
      logic        call;
      logic [15:0] addr;
      logic [2:0]  src;
      logic        level;
   } vec_req_s;

   typedef enum logic [1:0] {
      ST_RUN,
      ST_CALL,
      ST_WAIT
   } ctl_state_e;

endpackage

// *** src/six_source_two_level_irq_ctrl.sv ***
//
// What this block does
// RULE_01: six request sources, each assigned to one of two priority levels.
// RULE_02: per-source enable bits in interrupt_enable_reg at A8H; disabled never vectors.
// RULE_03: global_irq_gate bit 7 low blocks all; high lets individual enables decide.
// RULE_04: vectors 0003h external 0, 000Bh timer 0, 0013h external 1.
// RULE_05: accepted timer 1 request vectors to 001Bh.
// RULE_06: serial request is receive OR transmit done; vectors to 0023h.
// RULE_07: timer 2 request is rollover OR outside reload; vectors to 002Bh.
// RULE_08: same-level ties resolved: ext0, timer0, ext1, timer1, serial, timer2.
// RULE_09: active service is preempted only by a strictly higher level.
// RULE_10: return instruction ends the active level; core resumes where it left.
// RULE_11: request flags set on their condition whatever the enables say.
// RULE_12: flags sampled once per machine cycle, then samples polled.
// RULE_13: pending enabled request acknowledged next instruction cycle by a long call.
// RULE_14: latency depends on the running instruction, so it is not fixed.
// RULE_15: timer2_irq_allow bit 5 permits or blocks timer 2 requests.
// RULE_16: serial_irq_allow bit 4 permits or blocks the serial request.
// RULE_17: timer1_irq_allow bit 3 and timer0_irq_allow bit 1 gate timer overflows.
// RULE_18: outside_line1 bit 2 and outside_line0 bit 0 allows gate external lines.
// RULE_19: level register at B8H, same bit layout as enable register.
// RULE_20: level bit 1 is the higher level, 0 the lower; polling order breaks ties.
// RULE_21: serial done flags set by hardware, cleared only by software, not vectoring.
// RULE_22: enabled interrupt during idle clears the idle bit in hardware.
//
// Our own choice: register access over Wishbone.
`timescale 1ns/100ps
`include "irq_ctrl_regs.svh"

module six_source_two_level_irq_ctrl (
   // clock, reset, enable
   input  wire logic                   clk_i,
   input  wire logic                   rst_i,
   input  wire logic                   ce_i,
   // wishbone slave
   input  wire logic                   cyc_i,
   input  wire logic                   stb_i,
   input  wire logic                   we_i,
   input  wire logic [7:0]             adr_i,
   input  wire logic [3:0]             sel_i,
   input  wire logic [31:0]            dat_i,
   output logic      [31:0]            dat_o,
   output logic                        ack_o,
   // peripheral flag sources, one-cycle set pulses
   input  wire irq_ctrl_pkg::flag_in_s flag_set_i,
   // core sequencer
   input  wire logic                   mc_tick_i,
   input  wire logic                   instr_end_i,
   input  wire logic                   call_taken_i,
   input  wire logic                   return_from_irq_instr_i,
   output irq_ctrl_pkg::vec_req_s      vec_req_o,
   output logic                        idle_o
);
   import irq_ctrl_pkg::*;

   // ==========================================================
   // registers and state
   // ==========================================================
   logic [7:0]  int_enable_r;
   logic [7:0]  int_level_r;
   logic        idle_r;
   logic        rx_done_r;
   logic        tx_done_r;
   logic        t2_ovf_r;
   logic        t2_ext_r;
   logic [3:0]  flag_lo_r;     // ext0, tmr0, ext1, tmr1
   src_vec_t    raw_req;
   src_vec_t    sample_r;
   logic [1:0]  active_r;      // bit1 high level in service, bit0 low level
   ctl_state_e  state_r;
   logic        wb_hit;
   logic        wr_stb;

   // ==========================================================
   // decoding helpers
   // ==========================================================
   function automatic logic [15:0] vec_of(input logic [2:0] s);
      logic [15:0] v;
      v = `VEC_EXT0;
      unique case (s)
         3'h0: v = `VEC_EXT0;                        // see RULE_04
         3'h1: v = `VEC_TMR0;                        // see RULE_04
         3'h2: v = `VEC_EXT1;                        // see RULE_04
         3'h3: v = `VEC_TMR1;                        // see RULE_05
         3'h4: v = `VEC_SER;                         // see RULE_06
         3'h5: v = `VEC_TMR2;                        // see RULE_07
         default: v = `VEC_EXT0;
      endcase
      return v;
   endfunction

   // lowest index wins, giving the fixed polling order
   function automatic logic [2:0] first_of(input src_vec_t m);
      logic [2:0] r;
      r = 3'h0;
      for (int i = `NUM_SOURCES - 1; i >= 0; i--) begin
         if (m[i]) begin
            r = 3'(i);                               // see RULE_08
         end
      end
      return r;
   endfunction

   // ==========================================================
   // wishbone slave: one wait state, ack for one cycle
   // ==========================================================
   assign wb_hit = cyc_i && stb_i && !ack_o;
   assign wr_stb = ce_i && wb_hit && we_i && sel_i[0];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else if (ce_i) begin
         ack_o <= wb_hit;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0000_0000;
      end else if (ce_i && wb_hit && !we_i) begin
         unique case (adr_i)
            `OFS_INT_ENABLE: dat_o <= {24'h00_0000, int_enable_r};
            `OFS_INT_LEVEL:  dat_o <= {24'h00_0000, int_level_r};
            `OFS_FLAGS:      dat_o <= {24'h00_0000, t2_ext_r, t2_ovf_r, tx_done_r,
                                       rx_done_r, flag_lo_r};
            `OFS_SERVICE:    dat_o <= {28'h000_0000, 2'(state_r), active_r};
            `OFS_POWER_CTL:  dat_o <= 32'h0000_0000;  // idle bit always reads zero
            default:         dat_o <= 32'h0000_0000;
         endcase
      end
   end

   // ==========================================================
   // control registers
   // ==========================================================
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         int_enable_r <= `RST_INT_ENABLE;
      end else if (wr_stb && adr_i == `OFS_INT_ENABLE) begin
         // bit 6 is unused and kept zero
         int_enable_r <= dat_i[7:0] & 8'hBF;         // see RULE_02
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         int_level_r <= `RST_INT_LEVEL;
      end else if (wr_stb && adr_i == `OFS_INT_LEVEL) begin
         int_level_r <= dat_i[7:0] & 8'h3F;          // see RULE_19
      end
   end

   // ==========================================================
   // request flags: a set in the same cycle as a clear wins
   // ==========================================================
   // external and timer 0/1 flags are cleared by vectoring or by software write-one
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flag_lo_r <= 4'h0;
      end else if (ce_i) begin
         for (int i = 0; i < 4; i++) begin
            if ((wr_stb && adr_i == `OFS_FLAGS && dat_i[i]) ||
                (state_r == ST_CALL && call_taken_i && vec_req_o.src == 3'(i))) begin
               flag_lo_r[i] <= 1'b0;
            end
         end
         // sets come last so they win, whatever the enables are
         if (flag_set_i.outside_line0_flag)   flag_lo_r[0] <= 1'b1; // see RULE_11
         if (flag_set_i.timer0_rollover_flag) flag_lo_r[1] <= 1'b1; // see RULE_11
         if (flag_set_i.outside_line1_flag)   flag_lo_r[2] <= 1'b1; // see RULE_11
         if (flag_set_i.timer1_rollover_flag) flag_lo_r[3] <= 1'b1; // see RULE_11
      end
   end

   // serial and timer 2 flags: only a software write-one clears them
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_done_r <= 1'b0;
         tx_done_r <= 1'b0;
         t2_ovf_r  <= 1'b0;
         t2_ext_r  <= 1'b0;
      end else if (ce_i) begin
         if (wr_stb && adr_i == `OFS_FLAGS) begin
            if (dat_i[4]) rx_done_r <= 1'b0;         // see RULE_21
            if (dat_i[5]) tx_done_r <= 1'b0;         // see RULE_21
            if (dat_i[6]) t2_ovf_r  <= 1'b0;
            if (dat_i[7]) t2_ext_r  <= 1'b0;
         end
         if (flag_set_i.receive_done_flag)          rx_done_r <= 1'b1; // see RULE_21
         if (flag_set_i.transmit_done_flag)         tx_done_r <= 1'b1; // see RULE_21
         if (flag_set_i.timer2_rollover_flag)       t2_ovf_r  <= 1'b1; // see RULE_11
         if (flag_set_i.timer2_outside_reload_flag) t2_ext_r  <= 1'b1; // see RULE_11
      end
   end

   assign raw_req = {t2_ovf_r | t2_ext_r,                  // see RULE_07
                     rx_done_r | tx_done_r,                // see RULE_06
                     flag_lo_r[3], flag_lo_r[2], flag_lo_r[1], flag_lo_r[0]};

   // ==========================================================
   // sampling and polling
   // ==========================================================
   src_vec_t   allowed;
   src_vec_t   hi_pend;
   src_vec_t   lo_pend;
   logic       can_hi;
   logic       can_lo;
   logic       go;
   logic [2:0] pick;

   // samples move only on the machine-cycle tick
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sample_r <= 6'h00;
      end else if (ce_i && mc_tick_i) begin
         sample_r <= raw_req;                        // see RULE_12
      end
   end

   // bits 5..0 gate each source; global gate in bit 7 over all
   assign allowed = sample_r & int_enable_r[5:0]     // see RULE_15 RULE_16 RULE_17 RULE_18
                    & {6{int_enable_r[`BIT_GLOBAL_GATE]}}; // see RULE_03
   assign hi_pend = allowed & int_level_r[5:0];      // see RULE_20
   assign lo_pend = allowed & ~int_level_r[5:0];     // see RULE_20
   // a level preempts only what is strictly below it
   assign can_hi  = |hi_pend && !active_r[1];        // see RULE_09
   assign can_lo  = |lo_pend && active_r == 2'b00;   // see RULE_09
   assign pick    = can_hi ? first_of(hi_pend) : first_of(lo_pend);
   // the call waits for an instruction boundary, so latency varies
   assign go      = (can_hi || can_lo) && instr_end_i; // see RULE_13 RULE_14

   // ==========================================================
   // call sequencing
   // ==========================================================
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r   <= ST_RUN;
         vec_req_o <= '0;
      end else if (ce_i) begin
         unique case (state_r)
            ST_RUN: begin
               if (go) begin
                  state_r        <= ST_CALL;
                  vec_req_o.call <= 1'b1;            // see RULE_13
                  vec_req_o.addr <= vec_of(pick);
                  vec_req_o.src  <= pick;
                  vec_req_o.level <= can_hi;
               end
            end
            ST_CALL: begin
               if (call_taken_i) begin
                  state_r        <= ST_WAIT;
                  vec_req_o.call <= 1'b0;
               end
            end
            // wait for the next machine-cycle tick so the cleared flag leaves the sample path
            ST_WAIT: begin
               if (mc_tick_i) begin
                  state_r <= ST_RUN;
               end
            end
            default: state_r <= ST_RUN;
         endcase
      end
   end

   // active level tracking; a return ends the highest level in service
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         active_r <= 2'b00;
      end else if (ce_i) begin
         if (state_r == ST_CALL && call_taken_i) begin
            active_r[vec_req_o.level] <= 1'b1;       // see RULE_01
         end else if (return_from_irq_instr_i) begin
            if (active_r[1]) begin
               active_r[1] <= 1'b0;                  // see RULE_10
            end else begin
               active_r[0] <= 1'b0;                  // see RULE_10
            end
         end
      end
   end

   // ==========================================================
   // idle control
   // ==========================================================
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         // only the idle bit of the power control word lives here
         idle_r <= 1'(`RST_POWER_CTL);
      end else if (ce_i) begin
         if (|allowed) begin
            idle_r <= 1'b0;                          // see RULE_22
         end else if (wr_stb && adr_i == `OFS_POWER_CTL && dat_i[`BIT_IDLE]) begin
            idle_r <= 1'b1;
         end
      end
   end

   assign idle_o = idle_r;

   // ==========================================================
   // checks
   // ==========================================================
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_gate_blocks_call: assert property (   // see RULE_03
      ce_i && state_r == ST_RUN && !int_enable_r[7] |=> !vec_req_o.call)
      else $error("call raised with global gate low");

   a_enable_blocks_src: assert property (  // see RULE_02
      ce_i && state_r == ST_RUN && go |-> int_enable_r[pick])
      else $error("call for a disabled source");

   a_vector_matches: assert property (     // see RULE_04
      vec_req_o.call |-> vec_req_o.addr == {10'h000, vec_req_o.src, 3'h3})
      else $error("vector address does not match source");

   a_no_equal_preempt: assert property (   // see RULE_09
      ce_i && state_r == ST_RUN && go && active_r[0] |-> can_hi)
      else $error("equal or lower level preempted service");

   a_call_holds: assert property (         // see RULE_13
      vec_req_o.call && !call_taken_i && ce_i |=> vec_req_o.call && $stable(vec_req_o.addr))
      else $error("call request dropped before taken");

   a_flag_set_wins: assert property (      // see RULE_11
      ce_i && flag_set_i.outside_line0_flag |=> flag_lo_r[0])
      else $error("external 0 flag lost");

   a_serial_kept: assert property (        // see RULE_21
      ce_i && rx_done_r && !wr_stb |=> rx_done_r)
      else $error("receive done cleared without software");

   a_idle_wakes: assert property (         // see RULE_22
      ce_i && |allowed |=> !idle_r)
      else $error("idle not ended by enabled interrupt");

   a_sample_tick: assert property (        // see RULE_12
      !mc_tick_i || !ce_i |=> $stable(sample_r))
      else $error("sample changed off the machine cycle");

   a_return_from_irq_instr_ends: assert property (          // see RULE_10
      ce_i && return_from_irq_instr_i && active_r == 2'b01 && !(state_r == ST_CALL && call_taken_i)
      |=> active_r == 2'b00)
      else $error("return did not end the level");

   // paired flags reach the sample at the first machine-cycle tick after they rise
   a_serial_pairing: assert property ( // see RULE_06
      ce_i && mc_tick_i && (rx_done_r || tx_done_r) |=> sample_r[4])
      else $error("serial done flag missing from the sample");

   a_t2_pairing: assert property (     // see RULE_07
      ce_i && mc_tick_i && (t2_ovf_r || t2_ext_r) |=> sample_r[5])
      else $error("timer 2 flag missing from the sample");

   a_poll_order: assert property (     // see RULE_08
      ce_i && state_r == ST_RUN && go
      |-> ((can_hi ? hi_pend : lo_pend) & ((6'h01 << pick) - 6'h01)) == 6'h00)
      else $error("a lower polling index was passed over");

   a_hi_level_first: assert property ( // see RULE_20
      ce_i && state_r == ST_RUN && go && |hi_pend && !active_r[1]
      |=> vec_req_o.level && int_level_r[vec_req_o.src])
      else $error("upper level request lost to the lower level");

   c_low_call:    cover property (vec_req_o.call && !vec_req_o.level);
   c_high_call:   cover property (vec_req_o.call && vec_req_o.level);
   c_nested:      cover property (active_r == 2'b11);
   c_idle_wake:   cover property (idle_r ##1 !idle_r);
   c_serial_call: cover property (vec_req_o.call && vec_req_o.src == 3'h4);

endmodule

// *** bench/core_seq_model.sv ***
`timescale 1ns/100ps

module core_seq_model (
   // clock and reset
   input  wire logic                   clk_i,
   input  wire logic                   rst_i,
   // bench control
   input  wire logic                   slow_i,
   input  wire logic                   ret_req_i,
   // controller side
   input  wire irq_ctrl_pkg::vec_req_s vec_req_i,
   output logic                        mc_tick_o,
   output logic                        instr_end_o,
   output logic                        call_taken_o,
   output logic                        return_from_irq_instr_o
);
   import irq_ctrl_pkg::*;

   logic [1:0] phase_r;
   logic       odd_r;
   logic [2:0] hold_r;

   // ==========================================================
   // machine cycles and instruction boundaries
   // four clocks a machine cycle; in slow mode instructions take two machine
   // cycles, so the call latency is not the same every time
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         phase_r     <= 2'h0;
         odd_r       <= 1'b0;
         mc_tick_o   <= 1'b0;
         instr_end_o <= 1'b0;
      end else begin
         phase_r     <= phase_r + 2'h1;
         mc_tick_o   <= (phase_r == 2'h3);
         instr_end_o <= (phase_r == 2'h0) && (odd_r || !slow_i);
         if (phase_r == 2'h3) begin
            odd_r <= !odd_r;
         end
      end
   end

   // ==========================================================
   // long call acceptance, prompt or after a stall
   always_ff @(posedge clk_i) begin
      if (rst_i || !vec_req_i.call || call_taken_o) begin
         hold_r       <= 3'h0;
         call_taken_o <= 1'b0;
      end else if (hold_r >= (slow_i ? 3'h5 : 3'h0)) begin
         call_taken_o <= 1'b1;
      end else begin
         hold_r <= hold_r + 3'h1;
      end
   end

   // ==========================================================
   // return from the service routine
   always_ff @(posedge clk_i) begin
      return_from_irq_instr_o <= rst_i ? 1'b0 : ret_req_i;
   end

endmodule

// *** bench/testbench.sv ***
`timescale 1ns/100ps
`include "irq_ctrl_regs.svh"

module testbench;
   import irq_ctrl_pkg::*;

   logic        clk_i      = 1'b0;
   logic        rst_i      = 1'b1;
   logic        cyc_i      = 1'b0;
   logic        stb_i      = 1'b0;
   logic        we_i       = 1'b0;
   logic [7:0]  adr_i      = 8'h00;
   logic [3:0]  sel_i      = 4'h0;
   logic [31:0] dat_i      = 32'h0;
   logic [31:0] dat_o;
   logic        ack_o;
   flag_in_s    flag_set_i = '0;
   logic        mc_tick_i;
   logic        instr_end_i;
   logic        call_taken_i;
   logic        return_from_irq_instr_i;
   vec_req_s    vec_req_o;
   logic        idle_o;
   logic        slow       = 1'b0;
   logic        ce         = 1'b1;
   logic        ret_req    = 1'b0;
   logic [31:0] rd;
   int          n_errors   = 0;
   int          checked    = 0;
   int          cycles     = 0;
   int          srcmap [8] = '{0, 1, 2, 3, 4, 4, 5, 5};
   logic [15:0] vecs [6]   = '{`VEC_EXT0, `VEC_TMR0, `VEC_EXT1, `VEC_TMR1, `VEC_SER, `VEC_TMR2};
   logic [7:0]  clrs [6]   = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h30, 8'hC0};

   always #20 clk_i = ~clk_i;

   six_source_two_level_irq_ctrl uut (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
      .ack_o(ack_o), .flag_set_i(flag_set_i), .mc_tick_i(mc_tick_i),
      .instr_end_i(instr_end_i), .call_taken_i(call_taken_i), .return_from_irq_instr_i(return_from_irq_instr_i),
      .vec_req_o(vec_req_o), .idle_o(idle_o));

   core_seq_model core (
      .clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .ret_req_i(ret_req),
      .vec_req_i(vec_req_o), .mc_tick_o(mc_tick_i), .instr_end_o(instr_end_i),
      .call_taken_o(call_taken_i), .return_from_irq_instr_o(return_from_irq_instr_i));

   // ==========================================================
   // helpers
   task automatic close_out();
      $display("comparisons %0d, mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   // one classic wishbone cycle; no fixed latency is assumed
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      sel_i <= 4'h1;
      dat_i <= {24'h0, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i  <= 1'b0;
      if (n >= 50) begin
         n_errors++;
      end
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 8'h00);
      check(rd, exp);
   endtask

   task automatic pulse(input flag_in_s v);
      @(posedge clk_i);
      flag_set_i <= v;
      @(posedge clk_i);
      flag_set_i <= '0;
   endtask

   // waits for the call, checks it, then lets the core take it
   task automatic expect_call(input logic [15:0] addr, input logic lvl);
      int n;
      n = 0;
      while (vec_req_o.call !== 1'b1 && n < 200) begin
         @(posedge clk_i);
         n++;
      end
      check({31'h0, vec_req_o.call}, 32'h1);
      check({16'h0, vec_req_o.addr}, {16'h0, addr});
      check({31'h0, vec_req_o.level}, {31'h0, lvl});
      while (vec_req_o.call === 1'b1 && n < 400) begin
         @(posedge clk_i);
         n++;
      end
   endtask

   task automatic none(input int cyc);
      int hits;
      hits = 0;
      repeat (cyc) begin
         @(posedge clk_i);
         if (vec_req_o.call !== 1'b0) begin
            hits++;
         end
      end
      check(hits, 32'h0);
   endtask

   task automatic ret();
      @(posedge clk_i);
      ret_req <= 1'b1;
      @(posedge clk_i);
      ret_req <= 1'b0;
      repeat (4) @(posedge clk_i);
   endtask

   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors++;
         close_out();
      end
   end

   // ==========================================================
   // scenarios
   initial begin
      int s;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_chk(`OFS_INT_ENABLE, 32'h00);
      rd_chk(`OFS_INT_LEVEL, 32'h00);
      wb(1'b1, `OFS_INT_LEVEL, 8'h2A);
      rd_chk(`OFS_INT_LEVEL, 32'h2A);
      wb(1'b1, 8'h10, 8'hFF);
      rd_chk(8'h10, 32'h00);
      wb(1'b1, `OFS_INT_LEVEL, 8'h00);
      // flags rise while everything is gated
      pulse(8'hFF);
      rd_chk(`OFS_FLAGS, 32'hFF);
      none(40);
      wb(1'b1, `OFS_INT_ENABLE, 8'h3F);
      none(40);
      wb(1'b1, `OFS_FLAGS, 8'hFF);
      rd_chk(`OFS_FLAGS, 32'h00);
      // each flag: held off by its own enable, then vectored
      for (int f = 0; f < 8; f++) begin
         s = srcmap[f];
         slow <= f[0];
         wb(1'b1, `OFS_INT_ENABLE, 8'hBF & ~(8'h01 << s));
         pulse(flag_in_s'(8'h80 >> f));
         none(40);
         wb(1'b1, `OFS_INT_ENABLE, 8'h80 | (8'h01 << s));
         expect_call(vecs[s], 1'b0);
         rd_chk(`OFS_FLAGS, (s >= 4) ? (32'h1 << f) : 32'h0);
         wb(1'b1, `OFS_FLAGS, 8'hFF);
         ret();
      end
      // all at once, one level: fixed polling order
      wb(1'b1, `OFS_INT_ENABLE, 8'hBF);
      pulse(8'hFF);
      for (int k = 0; k < 6; k++) begin
         expect_call(vecs[k], 1'b0);
         wb(1'b1, `OFS_FLAGS, clrs[k]);
         ret();
      end
      // timer 2 in the upper level beats external 0 and preempts
      wb(1'b1, `OFS_INT_LEVEL, 8'h20);
      pulse(8'h82);
      expect_call(`VEC_TMR2, 1'b1);
      wb(1'b1, `OFS_FLAGS, 8'hC0);
      ret();
      expect_call(`VEC_EXT0, 1'b0);
      pulse(8'h40);
      none(40);
      pulse(8'h02);
      expect_call(`VEC_TMR2, 1'b1);
      wb(1'b1, `OFS_FLAGS, 8'hC0);
      rd_chk(`OFS_SERVICE, 32'h03);
      ret();
      none(40);
      ret();
      expect_call(`VEC_TMR0, 1'b0);
      ret();
      // idle ends only on an enabled request
      wb(1'b1, `OFS_INT_LEVEL, 8'h00);
      wb(1'b1, `OFS_INT_ENABLE, 8'h80);
      wb(1'b1, `OFS_POWER_CTL, 8'h01);
      @(posedge clk_i);
      check({31'h0, idle_o}, 32'h1);
      rd_chk(`OFS_POWER_CTL, 32'h00);
      pulse(8'h80);
      none(40);
      check({31'h0, idle_o}, 32'h1);
      wb(1'b1, `OFS_INT_ENABLE, 8'h81);
      expect_call(`VEC_EXT0, 1'b0);
      check({31'h0, idle_o}, 32'h0);
      ret();
      // a frozen block ignores a flag pulse
      @(posedge clk_i);
      ce <= 1'b0;
      pulse(8'h40);
      @(posedge clk_i);
      ce <= 1'b1;
      rd_chk(`OFS_FLAGS, 32'h00);
      close_out();
   end

endmodule
